/* File: src/lips_cfg_if.sv */
// Configuration and result bundle between register bank and pipe map
`timescale 1ns/10ps
interface lips_cfg_if;
  logic [3:0] link_gen2;
  logic [3:0] link_enable;
  logic [3:0] link_hold;
  logic [3:0] link_pulse;
  logic [7:0] psel_01;
  logic [7:0] psel_23;
  logic [3:0] pipe_on;
  logic sel_all;
  logic [15:0] stream_active;
  logic [7:0] pipe_link;
  logic [15:0] pipe_stream_mask;
  logic [3:0] pipe_active;
  logic [3:0] pipe_reset;
  modport regs (
    output link_gen2, link_enable, link_hold, link_pulse,
    output psel_01, psel_23, pipe_on, sel_all, stream_active,
    input pipe_link, pipe_stream_mask, pipe_active, pipe_reset
  );
  modport pipes (
    input link_gen2, link_enable, link_hold, link_pulse,
    input psel_01, psel_23, pipe_on, sel_all, stream_active,
    output pipe_link, pipe_stream_mask, pipe_active, pipe_reset
  );
endinterface

/* File: src/lips_pipe_map.sv */
// Video pipe to link and stream routing with per-pipe reset
`timescale 1ns/10ps
module lips_pipe_map (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Configuration in, routing out
  lips_cfg_if.pipes cfg
);
  logic [7:0] next_link;
  logic [15:0] next_mask;
  logic [3:0] next_active;
  logic [3:0] next_reset;

  // Two-bit code to one-hot nibble
  function automatic logic [3:0] onehot(input logic [1:0] code);
    onehot = 4'h1 << code;
  endfunction

  // Route each pipe; gen1 links feed their own pipe
  always_comb begin
    logic [7:0] sel;
    logic [1:0] lk;
    sel = 8'h00;
    lk = 2'h0;
    next_link = 8'h00;
    next_mask = 16'h0000;
    next_active = 4'h0;
    next_reset = 4'h0;
    for (int p = 0; p < 4; p++) begin
      sel = (p < 2) ? cfg.psel_01 : cfg.psel_23;
      if (!cfg.link_gen2[p]) begin
        lk = 2'(p);
        next_mask[p*4 +: 4] = lips_pkg::GEN1_STREAM_MASK;
      end else begin
        lk = sel[(p%2)*4+2 +: 2];
        if (cfg.sel_all) begin
          next_mask[p*4 +: 4] = cfg.stream_active[lk*4 +: 4];
        end else begin
          next_mask[p*4 +: 4] = onehot(sel[(p%2)*4 +: 2]);
        end
      end
      next_link[p*2 +: 2] = lk;
      next_active[p] = cfg.pipe_on[p] & cfg.link_enable[lk];
      next_reset[p] = cfg.link_hold[lk] | cfg.link_pulse[lk];
    end
  end

  // Register routing
  always_ff @(posedge clock) begin
    if (reset) begin
      cfg.pipe_link <= 8'h00;
      cfg.pipe_stream_mask <= 16'h0000;
      cfg.pipe_active <= 4'h0;
      cfg.pipe_reset <= 4'hF;
    end else begin
      cfg.pipe_link <= next_link;
      cfg.pipe_stream_mask <= next_mask;
      cfg.pipe_active <= next_active;
      cfg.pipe_reset <= next_reset;
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  a_pipe_reset_link: assert property (
    cfg.link_pulse[0] && cfg.link_gen2[1] && cfg.psel_01[7:6] == 2'h0
    |=> cfg.pipe_reset[1])
    else $error("pipe fed by reset link not reset");
  a_gen1_default: assert property (
    !cfg.link_gen2[2] |=> cfg.pipe_link[5:4] == 2'h2)
    else $error("gen1 link not on its own pipe");
  a_copy_same: assert property (
    cfg.link_gen2[0] && cfg.link_gen2[1] && !cfg.sel_all
    && cfg.psel_01[3:0] == cfg.psel_01[7:4]
    |=> cfg.pipe_stream_mask[3:0] == cfg.pipe_stream_mask[7:4])
    else $error("duplicated pipes differ");
endmodule

/* File: src/lips_pkg.sv */
// Constants, codes and types of the link init and pipe select block
// Functional notes
// - Mode/enable register resets FF, gen2 and enables
// - Two rate registers, reverse/forward fields per link
// - Reverse 00 187.5M; forward 01 3G, 10 6G
// - Reset bits 7:4 hold links in reset
// - Bits 3:0 fire self-clearing one-shot link reset
// - Link reset also resets pipes fed by it
// - Cable register resets FF, coax or twisted pair
// - Power-up pin sets all modes, then per-link
// - Open-drain lock: all enabled gen2 links locked
// - Gen2 per-link lock status at bit 3
// - Gen1 per-link lock status at bit 0
// - Gen2 lock comes from link, no software
// - Gen1 needs reverse control link brought up
// - Pipe select: link in upper, stream lower pair
// - Link select A..D, stream tag 0..3
// - Pipes with same selection each get copy
// - Pipe enable resets 1F, select-all and enables
// - Select-all takes every active stream of the selected link; otherwise the code takes one stream; both only for gen2 links, gen1 pipes get stream 0
// - Gen1 links map to own pipes, one enabled
package lips_pkg;
  // ----------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------
  localparam logic [15:0] ADDR_MODE_EN = 16'h0006;
  localparam logic [15:0] ADDR_RATE_AB = 16'h0010;
  localparam logic [15:0] ADDR_RATE_CD = 16'h0011;
  localparam logic [15:0] ADDR_LINK_RST = 16'h0018;
  localparam logic [15:0] ADDR_CABLE = 16'h0022;
  localparam logic [15:0] ADDR_PSEL_01 = 16'h00F0;
  localparam logic [15:0] ADDR_PSEL_23 = 16'h00F1;
  localparam logic [15:0] ADDR_PIPE_EN = 16'h00F4;
  localparam logic [15:0] ADDR_LOCK2_A = 16'h001A;
  localparam logic [15:0] ADDR_LOCK2_B = 16'h000A;
  localparam logic [15:0] ADDR_LOCK2_C = 16'h000B;
  localparam logic [15:0] ADDR_LOCK2_D = 16'h000C;
  localparam logic [15:0] ADDR_LOCK1_A = 16'h0BCB;
  localparam logic [15:0] ADDR_LOCK1_B = 16'h0CCB;
  localparam logic [15:0] ADDR_LOCK1_C = 16'h0DCB;
  localparam logic [15:0] ADDR_LOCK1_D = 16'h0ECB;
  // ----------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------
  localparam logic [7:0] RST_MODE_EN = 8'hFF;
  localparam logic [7:0] RST_RATE = 8'h22;
  localparam logic [3:0] RST_LINK_HOLD = 4'h0;
  localparam logic [7:0] RST_CABLE = 8'hFF;
  localparam logic [7:0] RST_PSEL_01 = 8'h62;
  localparam logic [7:0] RST_PSEL_23 = 8'hEA;
  localparam logic [4:0] RST_PIPE_EN = 5'h1F;
  // ----------------------------------------------------------
  // Field layout and codes
  // ----------------------------------------------------------
  localparam logic [7:0] LOCK2_MASK = 8'h08;
  localparam logic [7:0] LOCK1_MASK = 8'h01;
  localparam logic [1:0] REV_187M5 = 2'h0;
  localparam logic [1:0] FWD_3G = 2'h1;
  localparam logic [1:0] FWD_6G = 2'h2;
  localparam logic [3:0] GEN1_STREAM_MASK = 4'h1;
  // Start-up sequencing of the mode strap capture
  typedef enum logic [1:0] {
    LIPS_INIT = 2'b00,
    LIPS_RUN = 2'b01
  } lips_state_t;
endpackage

/* File: src/lips_top.sv */
// Link init, lock report and pipe select register bank
`timescale 1ns/10ps
module lips_top (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register access
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Straps and link status
  input wire logic powerup_mode_pin,
  input wire logic [3:0] phy_lock_gen2,
  input wire logic [3:0] phy_lock_gen1,
  input wire logic [15:0] stream_active,
  // Link configuration
  output logic [3:0] link_enable,
  output logic [3:0] link_gen2,
  output logic [7:0] link_fwd_rate,
  output logic [7:0] link_rev_rate,
  output logic [3:0] link_rate_ok,
  output logic cable_kind_a,
  output logic cable_kind_b,
  output logic cable_kind_c,
  output logic cable_kind_d,
  // Link resets and reverse channel
  output logic [3:0] link_hold_reset,
  output logic [3:0] single_pulse_link_reset,
  output logic [3:0] reverse_ctrl_enable,
  // Open-drain lock pin
  output logic multi_function_pin_four_o,
  output logic multi_function_pin_four_oe,
  // Pipe routing
  output logic [7:0] pipe_link,
  output logic [15:0] pipe_stream_mask,
  output logic [3:0] pipe_active,
  output logic [3:0] pipe_reset
);
  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  lips_pkg::lips_state_t state, next_state;
  logic [7:0] mode_en, next_mode_en;
  logic [7:0] rate_ab, next_rate_ab;
  logic [7:0] rate_cd, next_rate_cd;
  logic [3:0] hold, next_hold;
  logic [3:0] pulse, next_pulse;
  logic [7:0] cable, next_cable;
  logic [7:0] psel_01, next_psel_01;
  logic [7:0] psel_23, next_psel_23;
  logic [4:0] pipe_en, next_pipe_en;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic [3:0] next_rate_ok;
  logic [3:0] next_rev_ctrl;
  logic next_lock_oe;
  logic all_locked;
  lips_cfg_if cfg ();

  // Valid pair of reverse and forward rate codes
  function automatic logic rate_valid(input logic [3:0] f);
    rate_valid = (f[3:2] == lips_pkg::REV_187M5)
      && (f[1:0] == lips_pkg::FWD_3G || f[1:0] == lips_pkg::FWD_6G);
  endfunction

  // Status byte from a lock level
  function automatic logic [7:0] lock_byte(input logic lk,
                                           input logic [7:0] mask);
    lock_byte = lk ? mask : 8'h00;
  endfunction

  // Lock pin condition over enabled gen2 links
  assign all_locked = &(~(mode_en[3:0] & mode_en[7:4]) | phy_lock_gen2);

  // ----------------------------------------------------------
  // Register writes and derived controls
  // ----------------------------------------------------------
  always_comb begin
    next_state = state;
    next_mode_en = mode_en;
    next_rate_ab = rate_ab;
    next_rate_cd = rate_cd;
    next_hold = hold;
    next_pulse = 4'h0;
    next_cable = cable;
    next_psel_01 = psel_01;
    next_psel_23 = psel_23;
    next_pipe_en = pipe_en;
    // Strap capture once after reset release
    case (state)
      lips_pkg::LIPS_INIT: begin
        next_mode_en[7:4] = {4{powerup_mode_pin}};
        next_state = lips_pkg::LIPS_RUN;
      end
      lips_pkg::LIPS_RUN: begin
        next_state = lips_pkg::LIPS_RUN;
      end
      default: begin
        next_state = lips_pkg::LIPS_INIT;
      end
    endcase
    if (reg_write) begin
      if (reg_addr == lips_pkg::ADDR_MODE_EN) begin
        next_mode_en = reg_wdata;
      end else if (reg_addr == lips_pkg::ADDR_RATE_AB) begin
        next_rate_ab = reg_wdata;
      end else if (reg_addr == lips_pkg::ADDR_RATE_CD) begin
        next_rate_cd = reg_wdata;
      end else if (reg_addr == lips_pkg::ADDR_LINK_RST) begin
        next_hold = reg_wdata[7:4];
        next_pulse = reg_wdata[3:0];
      end else if (reg_addr == lips_pkg::ADDR_CABLE) begin
        next_cable = reg_wdata;
      end else if (reg_addr == lips_pkg::ADDR_PSEL_01) begin
        next_psel_01 = reg_wdata;
      end else if (reg_addr == lips_pkg::ADDR_PSEL_23) begin
        next_psel_23 = reg_wdata;
      end else if (reg_addr == lips_pkg::ADDR_PIPE_EN) begin
        next_pipe_en[4] = reg_wdata[4];
        if (reg_wdata[3:0] != 4'h0) begin
          next_pipe_en[3:0] = reg_wdata[3:0];
        end
      end
    end
    next_rate_ok = {rate_valid(rate_cd[7:4]), rate_valid(rate_cd[3:0]),
                    rate_valid(rate_ab[7:4]), rate_valid(rate_ab[3:0])};
    next_rev_ctrl = mode_en[3:0] & ~mode_en[7:4] & ~hold;
    next_lock_oe = ~all_locked;
  end

  // ----------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------
  always_comb begin
    next_rvalid = reg_read;
    next_rdata = 8'h00;
    if (!reg_read) begin
      next_rdata = 8'h00;
    end else if (reg_addr == lips_pkg::ADDR_MODE_EN) begin
      next_rdata = mode_en;
    end else if (reg_addr == lips_pkg::ADDR_RATE_AB) begin
      next_rdata = rate_ab;
    end else if (reg_addr == lips_pkg::ADDR_RATE_CD) begin
      next_rdata = rate_cd;
    end else if (reg_addr == lips_pkg::ADDR_LINK_RST) begin
      next_rdata = {hold, 4'h0};
    end else if (reg_addr == lips_pkg::ADDR_CABLE) begin
      next_rdata = cable;
    end else if (reg_addr == lips_pkg::ADDR_PSEL_01) begin
      next_rdata = psel_01;
    end else if (reg_addr == lips_pkg::ADDR_PSEL_23) begin
      next_rdata = psel_23;
    end else if (reg_addr == lips_pkg::ADDR_PIPE_EN) begin
      next_rdata = {3'h0, pipe_en};
    end else if (reg_addr == lips_pkg::ADDR_LOCK2_A) begin
      next_rdata = lock_byte(phy_lock_gen2[0], lips_pkg::LOCK2_MASK);
    end else if (reg_addr == lips_pkg::ADDR_LOCK2_B) begin
      next_rdata = lock_byte(phy_lock_gen2[1], lips_pkg::LOCK2_MASK);
    end else if (reg_addr == lips_pkg::ADDR_LOCK2_C) begin
      next_rdata = lock_byte(phy_lock_gen2[2], lips_pkg::LOCK2_MASK);
    end else if (reg_addr == lips_pkg::ADDR_LOCK2_D) begin
      next_rdata = lock_byte(phy_lock_gen2[3], lips_pkg::LOCK2_MASK);
    end else if (reg_addr == lips_pkg::ADDR_LOCK1_A) begin
      next_rdata = lock_byte(phy_lock_gen1[0], lips_pkg::LOCK1_MASK);
    end else if (reg_addr == lips_pkg::ADDR_LOCK1_B) begin
      next_rdata = lock_byte(phy_lock_gen1[1], lips_pkg::LOCK1_MASK);
    end else if (reg_addr == lips_pkg::ADDR_LOCK1_C) begin
      next_rdata = lock_byte(phy_lock_gen1[2], lips_pkg::LOCK1_MASK);
    end else if (reg_addr == lips_pkg::ADDR_LOCK1_D) begin
      next_rdata = lock_byte(phy_lock_gen1[3], lips_pkg::LOCK1_MASK);
    end
  end

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= lips_pkg::LIPS_INIT;
      mode_en <= lips_pkg::RST_MODE_EN;
      rate_ab <= lips_pkg::RST_RATE;
      rate_cd <= lips_pkg::RST_RATE;
      hold <= lips_pkg::RST_LINK_HOLD;
      pulse <= 4'h0;
      cable <= lips_pkg::RST_CABLE;
      psel_01 <= lips_pkg::RST_PSEL_01;
      psel_23 <= lips_pkg::RST_PSEL_23;
      pipe_en <= lips_pkg::RST_PIPE_EN;
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      link_rate_ok <= 4'hF;
      reverse_ctrl_enable <= 4'h0;
      multi_function_pin_four_oe <= 1'b1;
      multi_function_pin_four_o <= 1'b0;
    end else begin
      state <= next_state;
      mode_en <= next_mode_en;
      rate_ab <= next_rate_ab;
      rate_cd <= next_rate_cd;
      hold <= next_hold;
      pulse <= next_pulse;
      cable <= next_cable;
      psel_01 <= next_psel_01;
      psel_23 <= next_psel_23;
      pipe_en <= next_pipe_en;
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
      link_rate_ok <= next_rate_ok;
      reverse_ctrl_enable <= next_rev_ctrl;
      multi_function_pin_four_oe <= next_lock_oe;
      multi_function_pin_four_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Outputs and pipe routing
  // ----------------------------------------------------------
  assign link_enable = mode_en[3:0];
  assign link_gen2 = mode_en[7:4];
  assign link_fwd_rate = {rate_cd[5:4], rate_cd[1:0],
                          rate_ab[5:4], rate_ab[1:0]};
  assign link_rev_rate = {rate_cd[7:6], rate_cd[3:2],
                          rate_ab[7:6], rate_ab[3:2]};
  assign cable_kind_a = cable[0];
  assign cable_kind_b = cable[2];
  assign cable_kind_c = cable[4];
  assign cable_kind_d = cable[6];
  assign link_hold_reset = hold;
  assign single_pulse_link_reset = pulse;
  assign cfg.link_gen2 = mode_en[7:4];
  assign cfg.link_enable = mode_en[3:0];
  assign cfg.link_hold = hold;
  assign cfg.link_pulse = pulse;
  assign cfg.psel_01 = psel_01;
  assign cfg.psel_23 = psel_23;
  assign cfg.pipe_on = pipe_en[3:0];
  assign cfg.sel_all = pipe_en[4];
  assign cfg.stream_active = stream_active;
  assign pipe_link = cfg.pipe_link;
  assign pipe_stream_mask = cfg.pipe_stream_mask;
  assign pipe_active = cfg.pipe_active;
  assign pipe_reset = cfg.pipe_reset;

  lips_pipe_map u_pipe_map (
    .clock(clock),
    .reset(reset),
    .cfg(cfg.pipes)
  );

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  a_pulse_fires: assert property (
    reg_write && reg_addr == lips_pkg::ADDR_LINK_RST
    |=> single_pulse_link_reset == $past(reg_wdata[3:0]))
    else $error("one-shot did not follow write");
  a_pulse_single: assert property (
    !(reg_write && reg_addr == lips_pkg::ADDR_LINK_RST)
    |=> single_pulse_link_reset == 4'h0)
    else $error("one-shot longer than a cycle");
  a_hold_level: assert property (
    reg_write && reg_addr == lips_pkg::ADDR_LINK_RST
    ##1 !(reg_write && reg_addr == lips_pkg::ADDR_LINK_RST)
    |=> link_hold_reset == $past(reg_wdata[7:4], 2))
    else $error("held reset lost");
  a_lock_pin: assert property (
    ##1 multi_function_pin_four_oe == !$past(all_locked))
    else $error("lock pin wrong");
  a_lock_read: assert property (
    reg_read && reg_addr == lips_pkg::ADDR_LOCK2_B
    |=> reg_rvalid && reg_rdata == {4'h0, $past(phy_lock_gen2[1]), 3'h0})
    else $error("lock status read wrong");
  a_reset_read: assert property (
    reg_rvalid && $past(reg_addr) == lips_pkg::ADDR_LINK_RST
    |-> reg_rdata[3:0] == 4'h0)
    else $error("one-shot bits read nonzero");
  a_pipe_min_one: assert property (
    pipe_en[3:0] != 4'h0)
    else $error("all pipes disabled");
  a_rate_decode: assert property (
    ##1 link_rate_ok[0] == ($past(rate_ab[3:2]) == 2'h0
      && ($past(rate_ab[1:0]) == 2'h1 || $past(rate_ab[1:0]) == 2'h2)))
    else $error("rate decode wrong");
  a_strap_mode: assert property (
    state == lips_pkg::LIPS_INIT && !reg_write
    |=> link_gen2 == {4{$past(powerup_mode_pin)}})
    else $error("strap mode not loaded");
  a_mode_write: assert property (
    reg_write && reg_addr == lips_pkg::ADDR_MODE_EN
    |=> {link_gen2, link_enable} == $past(reg_wdata))
    else $error("mode register write lost");
  a_rate_fields: assert property (
    reg_write && reg_addr == lips_pkg::ADDR_RATE_AB
    |=> link_fwd_rate[3:0]
      == {$past(reg_wdata[5:4]), $past(reg_wdata[1:0])})
    else $error("forward rate fields wrong");
  a_cable_write: assert property (
    reg_write && reg_addr == lips_pkg::ADDR_CABLE
    |=> {cable_kind_d, cable_kind_c, cable_kind_b, cable_kind_a}
      == {$past(reg_wdata[6]), $past(reg_wdata[4]),
          $past(reg_wdata[2]), $past(reg_wdata[0])})
    else $error("cable kind write lost");
  a_rev_ctrl: assert property (
    link_enable[3] && !link_gen2[3] && !link_hold_reset[3]
    |=> reverse_ctrl_enable[3])
    else $error("reverse control link not raised");
  a_gen1_lock_read: assert property (
    reg_read && reg_addr == lips_pkg::ADDR_LOCK1_D
    |=> reg_rdata == {7'h00, $past(phy_lock_gen1[3])})
    else $error("first generation lock read wrong");
endmodule

/* File: tb/lips_link_model.sv */
// Behavioural model of the four remote serializers on the links
`timescale 1ns/10ps
module lips_link_model #(
  parameter int LOCK_WAIT = 6
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Link controls from the block
  input wire logic [3:0] link_enable,
  input wire logic [3:0] link_gen2,
  input wire logic [3:0] link_hold_reset,
  input wire logic [3:0] single_pulse_link_reset,
  input wire logic [3:0] reverse_ctrl_enable,
  // Bench controls
  input wire logic [3:0] plugged,
  input wire logic [15:0] streams,
  // Lock and stream reports
  output logic [3:0] phy_lock_gen2,
  output logic [3:0] phy_lock_gen1,
  output logic [15:0] stream_active
);
  int cnt [4];
  // Training time per link, restarted by any link reset
  always @(posedge clock) begin
    for (int l = 0; l < 4; l++) begin
      if (reset || !plugged[l] || !link_enable[l] || link_hold_reset[l] ||
          single_pulse_link_reset[l]) begin
        cnt[l] <= 0;
      end else if (cnt[l] < LOCK_WAIT) begin
        cnt[l] <= cnt[l] + 1;
      end
    end
  end
  // Second generation locks alone, first needs reverse control
  always_comb begin
    for (int l = 0; l < 4; l++) begin
      phy_lock_gen2[l] = link_gen2[l] && cnt[l] == LOCK_WAIT;
      phy_lock_gen1[l] = !link_gen2[l] && reverse_ctrl_enable[l] &&
                         cnt[l] == LOCK_WAIT;
      stream_active[l*4+:4] = phy_lock_gen2[l] ? streams[l*4+:4] : 4'h0;
    end
  end
endmodule

/* File: tb/test_link_init_and_pipe_select.sv */
// Self-checking bench of the link init and pipe select block
`timescale 1ns/10ps
module test_link_init_and_pipe_select;
  logic clock, reset, reg_write, reg_read, reg_rvalid, powerup_mode_pin;
  logic [15:0] reg_addr, stream_active, pipe_stream_mask, streams;
  logic [7:0] reg_wdata, reg_rdata, link_fwd_rate, link_rev_rate, pipe_link;
  logic [3:0] phy_lock_gen2, phy_lock_gen1, link_enable, link_gen2, plugged;
  logic [3:0] link_rate_ok, link_hold_reset, single_pulse_link_reset;
  logic [3:0] reverse_ctrl_enable, pipe_active, pipe_reset;
  logic cable_kind_a, cable_kind_b, cable_kind_c, cable_kind_d;
  logic pin_o, pin_oe;
  logic [7:0] v;
  logic [7:0] exp_q [$];
  int fails = 0;
  int checks_done = 0;
  int seed;
  logic [15:0] ra [9] = '{16'h0006, 16'h0010, 16'h0011, 16'h0018, 16'h0022,
                          16'h00F0, 16'h00F1, 16'h00F4, 16'h0123};
  logic [7:0] rv [9] = '{8'hFF, 8'h22, 8'h22, 8'h00, 8'hFF, 8'h62, 8'hEA,
                         8'h1F, 8'h00};

  lips_top DUT (.clock(clock), .reset(reset), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .powerup_mode_pin(powerup_mode_pin), .phy_lock_gen2(phy_lock_gen2),
    .phy_lock_gen1(phy_lock_gen1), .stream_active(stream_active),
    .link_enable(link_enable), .link_gen2(link_gen2),
    .link_fwd_rate(link_fwd_rate), .link_rev_rate(link_rev_rate),
    .link_rate_ok(link_rate_ok), .cable_kind_a(cable_kind_a),
    .cable_kind_b(cable_kind_b), .cable_kind_c(cable_kind_c),
    .cable_kind_d(cable_kind_d), .link_hold_reset(link_hold_reset),
    .single_pulse_link_reset(single_pulse_link_reset),
    .reverse_ctrl_enable(reverse_ctrl_enable),
    .multi_function_pin_four_o(pin_o), .multi_function_pin_four_oe(pin_oe),
    .pipe_link(pipe_link), .pipe_stream_mask(pipe_stream_mask),
    .pipe_active(pipe_active), .pipe_reset(pipe_reset));

  lips_link_model PEER (.clock(clock), .reset(reset),
    .link_enable(link_enable), .link_gen2(link_gen2),
    .link_hold_reset(link_hold_reset),
    .single_pulse_link_reset(single_pulse_link_reset),
    .reverse_ctrl_enable(reverse_ctrl_enable), .plugged(plugged),
    .streams(streams), .phy_lock_gen2(phy_lock_gen2),
    .phy_lock_gen1(phy_lock_gen1), .stream_active(stream_active));

  // Clock of 4 ns period
  always #2 clock = ~clock;

  // ----------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------
  task automatic cmp_port(input logic [15:0] got, input logic [15:0] want);
    checks_done++;
    if (got !== want) begin
      fails++;
      $display("BAD %0t port %h expected %h", $time, got, want);
    end
  endtask

  task automatic cmp_read(input logic [7:0] got, input logic [7:0] want);
    checks_done++;
    if (got !== want) begin
      fails++;
      $display("BAD %0t read %h expected %h", $time, got, want);
    end
  endtask

  task automatic complete_run;
    if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_write = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clock);
    reg_read = 1'b1;
    reg_addr = a;
    exp_q.push_back(e);
    @(negedge clock);
    reg_read = 1'b0;
  endtask

  // Bounded wait for the lock pin enable to reach a level
  task automatic wait_pin(input logic lvl);
    for (int i = 0; i < 60; i++) begin
      @(negedge clock);
      if (pin_oe === lvl) return;
    end
    fails++;
    $display("BAD %0t lock pin wait ran out", $time);
    complete_run();
  endtask

  // Read results taken in order of request
  always @(negedge clock) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) cmp_read(reg_rdata, 8'hXX);
      else cmp_read(reg_rdata, exp_q.pop_front());
    end
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    powerup_mode_pin = 1'b1;
    plugged = 4'hF;
    seed = 32'hc208c92f;
    streams = 16'($random(seed));
    repeat (6) @(negedge clock);
    reset = 1'b0;
    for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
    cmp_port({cable_kind_d, cable_kind_c, cable_kind_b, cable_kind_a},
             16'h000F);
    cmp_port(link_fwd_rate, 16'h00AA);
    cmp_port({link_rev_rate, 4'h0, link_rate_ok}, 16'h000F);
    wait_pin(1'b0);
    rd(16'h001A, 8'h08);
    rd(16'h000C, 8'h08);
    rd(16'h0BCB, 8'h00);
    wr(16'h000A, 8'h00);
    rd(16'h000A, 8'h08);
    // One-shot and held link resets, no video running
    wr(16'h0018, 8'h0F);
    cmp_port(single_pulse_link_reset, 16'h000F);
    @(negedge clock);
    cmp_port({single_pulse_link_reset, pipe_reset}, 16'h000F);
    rd(16'h0018, 8'h00);
    wr(16'h0018, 8'h15);
    cmp_port({link_hold_reset, single_pulse_link_reset}, 16'h0015);
    rd(16'h0018, 8'h10);
    cmp_port(pipe_reset, 16'h0001);
    wr(16'h0018, 8'h00);
    cmp_port(link_hold_reset, 16'h0000);
    // Lock pin ignores disabled links
    wait_pin(1'b0);
    plugged = 4'hB;
    wait_pin(1'b1);
    wr(16'h0006, 8'hFB);
    wait_pin(1'b0);
    wr(16'h0006, 8'h7B);
    wr(16'h0018, 8'h08);
    repeat (10) @(negedge clock);
    cmp_port(reverse_ctrl_enable, 16'h0008);
    cmp_port({link_gen2, link_enable}, 16'h007B);
    cmp_port(pin_o, 16'h0000);
    rd(16'h0ECB, 8'h01);
    rd(16'h000C, 8'h00);
    cmp_port({pipe_link[7:6], pipe_stream_mask[15:12]}, 16'h0031);
    plugged = 4'hF;
    wr(16'h0006, 8'hFF);
    wr(16'h0018, 8'h0F);
    wait_pin(1'b0);
    // Pipe routing, replication and select-all
    wr(16'h00F0, 8'h55);
    wr(16'h00F4, 8'h0F);
    repeat (3) @(negedge clock);
    cmp_port(pipe_link[3:0], 16'h0005);
    cmp_port(pipe_stream_mask[7:0], 16'h0022);
    wr(16'h00F4, 8'h05);
    wr(16'h00F4, 8'h10);
    rd(16'h00F4, 8'h15);
    repeat (3) @(negedge clock);
    cmp_port(pipe_active, 16'h0005);
    cmp_port(pipe_stream_mask[3:0], streams[7:4]);
    // Both low pipes on link A, then a one-shot on link A
    wr(16'h00F0, 8'h00);
    wr(16'h0018, 8'h01);
    @(negedge clock);
    cmp_port(pipe_reset, 16'h0003);
    // Random cable selections
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wr(16'h0022, v);
      rd(16'h0022, v);
      cmp_port({cable_kind_d, cable_kind_c, cable_kind_b, cable_kind_a},
               {12'h000, v[6], v[4], v[2], v[0]});
      wr(16'h0018, 8'h0F);
    end
    // Rate fields and reserved codes
    wr(16'h0011, 8'h11);
    wr(16'h0010, 8'h43);
    wr(16'h0018, 8'h0F);
    cmp_port(link_fwd_rate, 16'h0053);
    cmp_port({link_rev_rate, link_rate_ok}, 16'h04C);
    // Second reset with the strap low
    reset = 1'b1;
    powerup_mode_pin = 1'b0;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    rd(16'h0006, 8'h0F);
    repeat (2) @(negedge clock);
    cmp_port(pipe_link, 16'h00E4);
    repeat (3) @(negedge clock);
    complete_run();
  end
endmodule
